// >>> include/flash_pin_pkg.sv
// Package of constants and types for the serial flash pin logic
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package flash_pin_pkg;

	// Bus width modes of the current command
	typedef enum logic [1:0] {
		width_single = 2'b00,
		width_dual = 2'b01,
		width_quad = 2'b10
	} width_t;

	// Interface state
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_active = 2'b01,
		st_hold = 2'b10
	} if_state_t;

	localparam int unsigned fifo_width = 8;
	localparam int unsigned fifo_depth = 16;
	localparam logic [7:0] byte_reset = 8'h00;
	localparam logic [2:0] bit_cnt_reset = 3'h0;
	localparam logic [3:0] nibble_msb = 4'h7;

endpackage

// >>> include/byte_stream_if.sv
// Interface carrying a valid/ready byte stream between modules
`timescale 1ns/1ps
interface byte_stream_if;
	logic [7:0] data; // Byte payload
	logic valid; // Source offers a byte
	logic ready; // Sink takes the byte
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// >>> core/stream_fifo.sv
// Parameterised valid/ready FIFO for read data bytes
`timescale 1ns/1ps
module stream_fifo #(
	parameter int unsigned width = 8,
	parameter int unsigned depth = 16
) (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Async reset, active high
	input wire logic flush, // Drop all contents
	byte_stream_if.snk wr, // Filling side
	byte_stream_if.src rd // Draining side
);
	localparam int unsigned aw = $clog2(depth);

	logic [width-1:0] mem [depth]; // Storage array
	logic [aw:0] wr_ptr_q; // Write pointer with wrap bit
	logic [aw:0] rd_ptr_q; // Read pointer with wrap bit
	logic full; // No room left
	logic empty; // Nothing stored

	assign empty = (wr_ptr_q == rd_ptr_q);
	assign full = (wr_ptr_q[aw] != rd_ptr_q[aw]) &&
		(wr_ptr_q[aw-1:0] == rd_ptr_q[aw-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[rd_ptr_q[aw-1:0]];

	// Storage write, no reset needed for data
	always_ff @(posedge sys_clk) begin
		if (wr.valid && !full) begin
			mem[wr_ptr_q[aw-1:0]] <= wr.data;
		end
	end

	// Write pointer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
		end else if (wr.valid && !full) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ptr_q <= '0;
		end else if (flush) begin
			rd_ptr_q <= '0;
		end else if (rd.ready && !empty) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule

// >>> core/flash_pin_io.sv
// Pin-level serial interface of a multi-line serial flash
`timescale 1ns/1ps
module flash_pin_io (
	input wire logic sys_clk, // System clock, 25 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic chip_select_n, // Select from host, low active
	input wire logic serial_clk, // Serial clock level, sampled
	input wire logic data_line_zero_i, // Line zero input level
	output logic data_line_zero_o, // Line zero drive value
	output logic data_line_zero_oe, // Line zero drive enable
	input wire logic data_line_one_i, // Line one input level
	output logic data_line_one_o, // Line one drive value
	output logic data_line_one_oe, // Line one drive enable
	input wire logic data_line_two_i, // Protect pin or line two
	output logic data_line_two_o, // Line two drive value
	output logic data_line_two_oe, // Line two drive enable
	input wire logic data_line_three_i, // Hold pin or line three
	output logic data_line_three_o, // Line three drive value
	output logic data_line_three_oe, // Line three drive enable
	input wire logic quad_enable_bit, // Quad mode enabled
	input wire logic status_write_disable, // Status write disable
	input wire flash_pin_pkg::width_t cmd_width, // Width of transfer
	input wire logic cmd_ddr, // Double rate transfer
	input wire logic cmd_read, // Device drives data now
	input wire logic write_registers_cmd, // Register write in decode
	input wire logic [7:0] rd_byte, // Read data byte offered
	input wire logic rd_valid, // Read byte offered
	output logic rd_ready, // FIFO not full, registered one cycle late
	input wire logic op_busy_i, // Internal operation running
	output logic [7:0] rx_byte, // Received byte
	output logic rx_valid, // Received byte pulse
	output logic reg_write_allowed, // Register write may proceed
	output logic hold_active, // Hold condition level
	output logic if_reset, // Interface reset pulse
	output logic op_busy_o // Internal operation still running
);
	import flash_pin_pkg::*;

	// ---------------------------------------------------------------
	// Edge detection of the sampled serial clock
	// ---------------------------------------------------------------
	logic sck_q; // Previous clock level
	logic cs_n_q; // Previous select level
	logic sck_rise; // Serial clock rising
	logic sck_fall; // Serial clock falling
	logic selected; // Device selected now
	logic hold_pin_n; // Hold pin level when in use
	logic cs_rise; // Select going inactive

	// Pin inputs are synchronous, so one stage is enough
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sck_q <= serial_clk;
			cs_n_q <= chip_select_n;
		end
	end

	assign sck_rise = serial_clk && !sck_q;
	assign sck_fall = !serial_clk && sck_q;
	assign selected = !chip_select_n;
	assign cs_rise = chip_select_n && !cs_n_q;
	// Quad mode turns the hold pin into a data line
	assign hold_pin_n = quad_enable_bit ? 1'b1 : data_line_three_i;

	// ---------------------------------------------------------------
	// Interface state: idle, active, hold
	// ---------------------------------------------------------------
	if_state_t state_q;
	if_state_t state_d;

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			st_idle: begin
				// Resume only with hold pin high at selection
				if (selected && hold_pin_n) begin
					state_d = st_active;
				end
			end
			st_active: begin
				if (!selected) begin
					state_d = st_idle;
				end else if (!hold_pin_n && !serial_clk) begin
					// Hold only while selected, with clock low
					state_d = st_hold;
				end
			end
			st_hold: begin
				if (!selected) begin
					// Deselect during hold abandons transfer
					state_d = st_idle;
				end else if (hold_pin_n && !serial_clk) begin
					state_d = st_active;
				end
			end
			default: state_d = st_idle;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	logic active; // Transfer may proceed
	assign active = (state_q == st_active) && (state_d == st_active);

	// ---------------------------------------------------------------
	// Receive shifter
	// ---------------------------------------------------------------
	logic [7:0] rx_sh_q; // Shift register in
	logic [2:0] rx_cnt_q; // Bits collected, modulo eight
	logic [3:0] in_bits; // Lines sampled this edge
	logic rx_edge; // Edge on which inputs are taken

	assign in_bits = {data_line_three_i, data_line_two_i,
		data_line_one_i, data_line_zero_i};
	// Double rate samples on both edges, single on rise only
	assign rx_edge = active && !cmd_read &&
		(sck_rise || (cmd_ddr && sck_fall));

	// Step in one, two or four bits; line zero is least significant
	function automatic logic [11:0] shift_in(input logic [7:0] sh,
		input logic [2:0] cnt, input logic [3:0] bits, input width_t w);
		logic [7:0] n;
		logic [2:0] c;
		n = sh;
		c = cnt;
		unique case (w)
			width_dual: begin
				n = {sh[5:0], bits[1:0]};
				c = cnt + 3'h2;
			end
			width_quad: begin
				n = {sh[3:0], bits};
				c = cnt + 3'h4;
			end
			default: begin
				n = {sh[6:0], bits[0]};
				c = cnt + 3'h1;
			end
		endcase
		return {1'b0, c, n};
	endfunction

	logic [11:0] rx_next; // Shifter result
	assign rx_next = shift_in(rx_sh_q, rx_cnt_q, in_bits, cmd_width);

	// Collect bits, emit a byte on wrap; reset on deselect
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_sh_q <= byte_reset;
			rx_cnt_q <= bit_cnt_reset;
			rx_byte <= byte_reset;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!selected) begin
				rx_cnt_q <= bit_cnt_reset;
			end else if (rx_edge) begin
				rx_sh_q <= rx_next[7:0];
				rx_cnt_q <= rx_next[10:8];
				if (rx_next[10:8] == bit_cnt_reset) begin
					rx_byte <= rx_next[7:0];
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Read data path through a FIFO
	// ---------------------------------------------------------------
	byte_stream_if fifo_in ();
	byte_stream_if fifo_out ();

	assign fifo_in.data = rd_byte;
	assign fifo_in.valid = rd_valid;

	// Flushed whenever the interface is reset by deselection
	stream_fifo #(.width(fifo_width), .depth(fifo_depth)) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.flush(!selected),
		.wr(fifo_in.snk),
		.rd(fifo_out.src)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ready <= 1'b0;
		end else begin
			rd_ready <= fifo_in.ready;
		end
	end

	logic [7:0] tx_sh_q; // Outgoing byte
	logic [2:0] tx_cnt_q; // Bits sent
	logic tx_loaded_q; // A byte is in the shifter
	logic tx_edge; // Edge on which outputs change
	logic [11:0] tx_next; // Shifter result

	// Single rate drives after fall, double rate after every edge
	assign tx_edge = active && cmd_read &&
		(sck_fall || (cmd_ddr && sck_rise));
	assign tx_next = shift_in(tx_sh_q, tx_cnt_q, 4'h0, cmd_width);
	assign fifo_out.ready = tx_edge &&
		(!tx_loaded_q || tx_next[10:8] == bit_cnt_reset);

	// Load from FIFO, shift out at each output edge
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_sh_q <= byte_reset;
			tx_cnt_q <= bit_cnt_reset;
			tx_loaded_q <= 1'b0;
		end else if (!selected) begin
			tx_cnt_q <= bit_cnt_reset;
			tx_loaded_q <= 1'b0;
		end else if (fifo_out.ready) begin
			tx_sh_q <= fifo_out.valid ? fifo_out.data : byte_reset;
			tx_cnt_q <= bit_cnt_reset;
			tx_loaded_q <= fifo_out.valid;
		end else if (tx_edge) begin
			tx_sh_q <= tx_next[7:0];
			tx_cnt_q <= tx_next[10:8];
		end
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	logic drive; // Device drives its data lines
	assign drive = active && cmd_read;

	// Float everything when deselected or held
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_line_zero_oe <= 1'b0;
			data_line_one_oe <= 1'b0;
			data_line_two_oe <= 1'b0;
			data_line_three_oe <= 1'b0;
		end else begin
			data_line_one_oe <= drive;
			data_line_zero_oe <= drive && (cmd_width != width_single);
			data_line_two_oe <= drive && quad_enable_bit &&
				(cmd_width == width_quad);
			data_line_three_oe <= drive && quad_enable_bit &&
				(cmd_width == width_quad);
		end
	end

	// Values: single on line one, groups with line zero lowest
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_line_zero_o <= 1'b0;
			data_line_one_o <= 1'b0;
			data_line_two_o <= 1'b0;
			data_line_three_o <= 1'b0;
		end else begin
			unique case (cmd_width)
				width_dual: begin
					data_line_one_o <= tx_sh_q[7];
					data_line_zero_o <= tx_sh_q[6];
					data_line_two_o <= 1'b0;
					data_line_three_o <= 1'b0;
				end
				width_quad: begin
					data_line_three_o <= tx_sh_q[7];
					data_line_two_o <= tx_sh_q[6];
					data_line_one_o <= tx_sh_q[5];
					data_line_zero_o <= tx_sh_q[4];
				end
				default: begin
					data_line_one_o <= tx_sh_q[7];
					data_line_zero_o <= 1'b0;
					data_line_two_o <= 1'b0;
					data_line_three_o <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Write protection and status outputs
	// ---------------------------------------------------------------
	// Protect pin only counts outside quad mode
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_write_allowed <= 1'b1;
		end else begin
			reg_write_allowed <= !(write_registers_cmd &&
				!data_line_two_i && status_write_disable &&
				!quad_enable_bit);
		end
	end

	// Hold does not stop internal operations
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_busy_o <= 1'b0;
			hold_active <= 1'b0;
			if_reset <= 1'b0;
		end else begin
			op_busy_o <= op_busy_i;
			hold_active <= (state_d == st_hold);
			if_reset <= cs_rise;
		end
	end
endmodule

// >>> verif/flash_pin_sva.sv
// Checker for the flash pin logic, bound to its top module
`timescale 1ns/1ps
module flash_pin_sva (
	input wire logic sys_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic chip_select_n, // Select
	input wire logic serial_clk, // Serial clock
	input wire logic data_line_two_i, // Protect pin
	input wire logic data_line_three_i, // Hold pin
	input wire logic data_line_one_oe, // Line one enable
	input wire logic quad_enable_bit, // Quad mode
	input wire logic status_write_disable, // Lock bit
	input wire logic write_registers_cmd, // Reg write
	input wire logic op_busy_i, // Busy in
	input wire logic op_busy_o, // Busy out
	input wire logic rx_valid, // Byte pulse
	input wire logic reg_write_allowed, // Write allowed
	input wire logic hold_active, // Hold level
	input wire logic if_reset // Reset pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// -------------------------------------------
	// Sequences
	// -------------------------------------------
	sequence s_sel;
		!chip_select_n [*3];
	endsequence
	sequence s_hreq;
		(!chip_select_n && !data_line_three_i && !serial_clk &&
			!quad_enable_bit) [*2];
	endsequence
	sequence s_hrel;
		(data_line_three_i && !serial_clk) [*2];
	endsequence
	// -------------------------------------------
	// Properties
	// -------------------------------------------
	property p_hold_in;
		s_sel ##0 s_hreq |-> ##[0:3] hold_active;
	endproperty
	property p_hold_out;
		s_hrel |-> ##[0:3] !hold_active;
	endproperty
	property p_hold_sel;
		$rose(hold_active) |-> !$past(chip_select_n);
	endproperty
	property p_hold_oe;
		hold_active [*3] |-> !data_line_one_oe;
	endproperty
	property p_hold_rx;
		hold_active [*3] |-> !rx_valid;
	endproperty
	property p_desel;
		chip_select_n [*3] |-> !data_line_one_oe && !hold_active;
	endproperty
	property p_ifr;
		$rose(chip_select_n) |-> ##[0:2] if_reset;
	endproperty
	property p_lock;
		write_registers_cmd && !data_line_two_i && status_write_disable &&
			!quad_enable_bit |=> !reg_write_allowed;
	endproperty
	property p_open;
		write_registers_cmd && (data_line_two_i || !status_write_disable ||
			quad_enable_bit) |=> reg_write_allowed;
	endproperty
	property p_busy;
		op_busy_o == $past(op_busy_i);
	endproperty
	property p_quad;
		quad_enable_bit && $past(quad_enable_bit) |-> !$rose(hold_active);
	endproperty
	a_hold_in: assert property (p_hold_in)
		else $error("hold not entered");
	a_hold_out: assert property (p_hold_out)
		else $error("hold not left");
	a_hold_sel: assert property (p_hold_sel)
		else $error("hold while deselected");
	a_hold_oe: assert property (p_hold_oe)
		else $error("line one driven in hold");
	a_hold_rx: assert property (p_hold_rx)
		else $error("byte taken in hold");
	a_desel: assert property (p_desel)
		else $error("active while deselected");
	a_ifr: assert property (p_ifr)
		else $error("no interface reset");
	a_lock: assert property (p_lock)
		else $error("locked write allowed");
	a_open: assert property (p_open)
		else $error("open write refused");
	a_busy: assert property (p_busy)
		else $error("busy not carried");
	a_quad: assert property (p_quad)
		else $error("hold in quad mode");
endmodule
bind flash_pin_io flash_pin_sva i_sva (.sys_clk, .sys_rst, .chip_select_n,
	.serial_clk, .data_line_two_i, .data_line_three_i, .data_line_one_oe,
	.quad_enable_bit, .status_write_disable, .write_registers_cmd,
	.op_busy_i, .op_busy_o, .rx_valid, .reg_write_allowed, .hold_active,
	.if_reset);

// >>> verif/spi_host_model.sv
// Host serial master model: select, clock and four lines
`timescale 1ns/1ps
module spi_host_model (
	input wire logic sys_clk, // System clock
	output logic cs_n, // Select, low active
	output logic sclk, // Serial clock, idle low
	output logic [3:0] dq, // Host drive of lines
	input wire logic [3:0] dq_in // Resolved line levels
);
	logic [7:0] rd_q; // Bits taken on rises
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dq = 4'hf;
		rd_q = 8'h00;
	end
	// Each clock phase lasts four system cycles
	task automatic wait4();
		repeat (4) @(posedge sys_clk);
	endtask
	// Select first, keep low through any hold
	task automatic sel();
		cs_n <= 1'b0;
		wait4();
	endtask
	// Clock parks low before release
	task automatic desel();
		wait4();
		cs_n <= 1'b1;
		wait4();
	endtask
	// Lines change while clock low, read bit taken at rise
	task automatic pulse(input logic [3:0] v);
		dq <= v;
		wait4();
		sclk <= 1'b1;
		rd_q <= {rd_q[6:0], dq_in[1]};
		wait4();
		sclk <= 1'b0;
	endtask
	// Protect or hold pin level, hold high to resume
	task automatic pin(input int i, input logic lvl);
		dq[i] <= lvl;
		wait4();
	endtask
	// Move the clock to one level and let it settle
	task automatic clk_to(input logic lvl);
		sclk <= lvl;
		wait4();
	endtask
endmodule

// >>> verif/tb_serial_flash_pin_io_hold_protect.sv
// Self-checking bench for the flash pin logic with host model
`timescale 1ns/1ps
module tb_serial_flash_pin_io_hold_protect;
	import flash_pin_pkg::*;
	logic sys_clk = 1'b0; // 25 MHz clock
	logic sys_rst = 1'b1; // Held four cycles
	logic cs_n, sclk, rd_ready, rx_valid, rwa, hact, ifr, busy_o;
	logic [3:0] dq, lvl, o, oe; // Host drive, wire, device drive
	logic quad = 1'b0, swd = 1'b0, rd = 1'b0, wrc = 1'b0, ddr = 1'b0;
	logic busy_i = 1'b0, rd_valid = 1'b0;
	logic [7:0] rd_byte = 8'h00, rx_byte, last_rx = 8'h00;
	width_t wid = width_single; // Transfer width
	int rx_cnt = 0, ifr_cnt = 0, bad_count = 0, tests_run = 0;
	always #20 sys_clk = ~sys_clk;
	// Device drive wins on a line, else the host level
	assign lvl = (oe & o) | (~oe & dq);
	flash_pin_io i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.chip_select_n(cs_n), .serial_clk(sclk),
		.data_line_zero_i(lvl[0]), .data_line_zero_o(o[0]),
		.data_line_zero_oe(oe[0]), .data_line_one_i(lvl[1]),
		.data_line_one_o(o[1]), .data_line_one_oe(oe[1]),
		.data_line_two_i(lvl[2]), .data_line_two_o(o[2]),
		.data_line_two_oe(oe[2]), .data_line_three_i(lvl[3]),
		.data_line_three_o(o[3]), .data_line_three_oe(oe[3]),
		.quad_enable_bit(quad), .status_write_disable(swd),
		.cmd_width(wid), .cmd_ddr(ddr), .cmd_read(rd),
		.write_registers_cmd(wrc), .rd_byte(rd_byte),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .op_busy_i(busy_i),
		.rx_byte(rx_byte), .rx_valid(rx_valid),
		.reg_write_allowed(rwa), .hold_active(hact), .if_reset(ifr),
		.op_busy_o(busy_o));
	spi_host_model i_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
		.dq(dq), .dq_in(lvl));
	// Record received bytes and reset pulses
	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1) begin
			last_rx <= rx_byte;
			rx_cnt <= rx_cnt + 1;
		end
		if (ifr === 1'b1) begin
			ifr_cnt <= ifr_cnt + 1;
		end
	end
	task automatic check(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Pulses k0.. of a byte, w lines each, MSB first
	task automatic tx(input logic [7:0] b, input int w, input int k0,
		input int n);
		logic [7:0] g;
		for (int k = k0; k < k0 + n; k++) begin
			g = (b >> (8 - w * (k + 1))) & ((8'h01 << w) - 8'h01);
			i_host.pulse((4'hf << w) | g[3:0]);
		end
	endtask
	// Bounded wait for one more byte
	task automatic wait_rx(input int n0, input logic [7:0] exp);
		for (int i = 0; i < 40 && rx_cnt == n0; i++) cyc(1);
		if (rx_cnt == n0) begin
			bad_count++;
			finish_test();
		end
		check("rx_byte", last_rx, exp);
	endtask
	task automatic t_rx_widths();
		logic [7:0] pat [3] = '{8'ha5, 8'h9c, 8'h69};
		int n0;
		for (int m = 0; m < 3; m++) begin
			quad <= (m == 2);
			wid <= width_t'(m);
			n0 = rx_cnt;
			i_host.sel();
			tx(pat[m], 1 << m, 0, 8 >> m);
			wait_rx(n0, pat[m]);
			check("hold_q", hact, 8'h00);
			i_host.desel();
		end
		quad <= 1'b0;
		wid <= width_single;
	endtask
	// Bits: expect, quad, lock, protect pin
	task automatic t_protect();
		logic [3:0] tab [4] = '{4'h2, 4'hb, 4'h8, 4'he};
		for (int i = 0; i < 4; i++) begin
			i_host.pin(2, tab[i][0]);
			swd <= tab[i][1];
			quad <= tab[i][2];
			wrc <= 1'b1;
			cyc(3);
			check("allow", rwa, {7'h0, tab[i][3]});
		end
		wrc <= 1'b0;
		quad <= 1'b0;
		i_host.pin(2, 1'b1);
	endtask
	task automatic t_hold();
		int n0;
		n0 = rx_cnt;
		i_host.sel();
		tx(8'hc3, 1, 0, 4);
		busy_i <= 1'b1;
		// Read asked at hold entry: lines must still stay released
		rd <= 1'b1;
		i_host.pin(3, 1'b0);
		check("hold_on", hact, 8'h01);
		check("oe_one", oe[1], 8'h00);
		i_host.pulse(4'h0);
		rd <= 1'b0;
		check("busy", busy_o, 8'h01);
		i_host.pin(3, 1'b1);
		check("hold_off", hact, 8'h00);
		tx(8'hc3, 1, 4, 4);
		wait_rx(n0, 8'hc3);
		busy_i <= 1'b0;
		i_host.desel();
	endtask
	task automatic t_hold_desel();
		int n0;
		n0 = ifr_cnt;
		i_host.sel();
		tx(8'hff, 1, 0, 3);
		i_host.pin(3, 1'b0);
		i_host.desel();
		check("ifr", 8'(ifr_cnt - n0), 8'h01);
		check("hold_q", hact, 8'h00);
		i_host.pin(3, 1'b1);
		n0 = rx_cnt;
		i_host.sel();
		tx(8'h5a, 1, 0, 8);
		wait_rx(n0, 8'h5a);
		i_host.desel();
	endtask
	// Fill the buffer until refused, drain it over the line
	task automatic t_read();
		int cnt;
		cnt = 0;
		i_host.sel();
		rd <= 1'b1;
		rd_byte <= 8'h10;
		rd_valid <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge sys_clk);
			if (rd_ready !== 1'b1) break;
			@(posedge sys_clk);
			cnt++;
			rd_byte <= 8'h10 + 8'(cnt);
		end
		@(posedge sys_clk);
		rd_valid <= 1'b0;
		check("fill", 8'(cnt), 8'(fifo_depth + 1));
		i_host.pulse(4'hf);
		for (int k = 0; k < 16; k++) begin
			tx(8'hff, 1, 0, 8);
			check("rd_data", i_host.rd_q, 8'h10 + 8'(k));
		end
		check("oe_one", oe[1], 8'h01);
		i_host.desel();
		check("oe_off", oe[1], 8'h00);
		check("ready", rd_ready, 8'h01);
		rd <= 1'b0;
	endtask
	// Quad double-rate read: a new nibble after each clock edge
	task automatic t_read_quad();
		quad <= 1'b1;
		wid <= width_quad;
		ddr <= 1'b1;
		i_host.sel();
		rd <= 1'b1;
		rd_byte <= 8'h6b;
		rd_valid <= 1'b1;
		cyc(1);
		rd_valid <= 1'b0;
		i_host.clk_to(1'b1);
		check("oe_quad", {4'h0, oe}, 8'h0f);
		check("nib_hi", {4'h0, lvl}, 8'h06);
		i_host.clk_to(1'b0);
		check("nib_lo", {4'h0, lvl}, 8'h0b);
		i_host.desel();
		rd <= 1'b0;
		ddr <= 1'b0;
		quad <= 1'b0;
		wid <= width_single;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cyc(2);
		t_rx_widths();
		t_protect();
		t_hold();
		t_hold_desel();
		t_read();
		t_read_quad();
		finish_test();
	end
endmodule
